//--- dsitp_pkg.sv
// Constants, register indices and field layout for the serial interrupt/timer/port register bank
package dsitp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [29:0] IDX_OUT_SET = 30'h0ffff7fd;
  localparam logic [29:0] IDX_OUT_CLR = 30'h0ffff7ff;
  localparam logic [29:0] IDX_IRQ_STATUS = 30'h0ffff7e0;
  localparam logic [29:0] IDX_IRQ_MASK = 30'h0ffff7e1;
  localparam logic [29:0] IDX_CUR_HIGH = 30'h0ffff7e2;
  localparam logic [29:0] IDX_CUR_LOW = 30'h0ffff7e3;
  localparam logic [29:0] IDX_PRE_HIGH = 30'h0ffff7e4;
  localparam logic [29:0] IDX_PRE_LOW = 30'h0ffff7e5;
  localparam logic [29:0] IDX_VECTOR = 30'h0ffff7e6;
  localparam logic [29:0] IDX_INPUT = 30'h0ffff7e7;
  localparam logic [29:0] IDX_OUT_FUNC = 30'h0ffff7e8;
  localparam logic [29:0] IDX_START = 30'h0ffff7e9;
  localparam logic [29:0] IDX_STOP = 30'h0ffff7ea;
  localparam logic [29:0] IDX_AUX = 30'h0ffff7eb;
  localparam logic [29:0] IDX_MODE_A = 30'h0ffff7ec;
  localparam logic [29:0] IDX_MODE_B = 30'h0ffff7ed;
  // Interrupt status and mask bit positions
  localparam int ST_TX_A = 0;
  localparam int ST_RX_A = 1;
  localparam int ST_BRK_A = 2;
  localparam int ST_DONE = 3;
  localparam int ST_TX_B = 4;
  localparam int ST_RX_B = 5;
  localparam int ST_BRK_B = 6;
  localparam int ST_COS = 7;
  // Mode-one select bit, aux control fields
  localparam int MODE_RF_BIT = 6;
  localparam int AUX_TIMER_BIT = 6;
  localparam int AUX_IEC_MSB = 2;
  // Reset values, read constants and output routing codes
  localparam logic [7:0] VECTOR_RST = 8'h0f;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] UNPINNED_ONES = 3'h7;
  localparam logic [1:0] ROUTE_DATA = 2'h0;
  localparam logic [1:0] ROUTE_ALT1 = 2'h1;
  localparam logic [1:0] ROUTE_ALT2 = 2'h2;
endpackage

//--- dsitp_sync.sv
// Two-flop synchroniser for the general input pins
`timescale 1ns/1ps
module dsitp_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- dsitp_regs.sv
// Interrupt, counter/timer and parallel port register bank on APB
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module dsitp_regs (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel status from the receivers and transmitters
  input wire logic chan_a_rx_ready,
  input wire logic chan_a_fifo_full,
  input wire logic chan_a_tx_ready,
  input wire logic chan_a_break_event,
  input wire logic chan_b_rx_ready,
  input wire logic chan_b_fifo_full,
  input wire logic chan_b_tx_ready,
  input wire logic chan_b_break_event,
  // Channel clocks for the output port functions
  input wire logic chan_a_tx16_clock,
  input wire logic chan_a_tx_clock,
  input wire logic chan_a_rx_clock,
  input wire logic chan_b_tx_clock,
  input wire logic chan_b_rx_clock,
  // Counter/timer
  input wire logic [15:0] counter_value,
  input wire logic counter_output,
  input wire logic count_done_event,
  output logic [15:0] counter_preload,
  output logic counter_start,
  output logic counter_stop,
  output logic timer_mode,
  // Pins
  input wire logic [2:0] input_pins,
  output logic [3:0] output_pins,
  // Interrupt
  output logic irq,
  output logic [7:0] irq_vector
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [29:0] idx;
  logic setup_ph;
  logic acc_ph;
  logic wr_en;
  logic rd_en;
  logic lane0;
  logic [7:0] wbyte;
  logic hit_any;
  assign idx = paddr[31:2];
  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable & pready;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign wr_en = acc_ph & pwrite & lane0;
  assign rd_en = acc_ph & ~pwrite;

  logic hit_set, hit_clr, hit_st, hit_mask, hit_ch, hit_cl, hit_ph, hit_pl;
  logic hit_vec, hit_in, hit_func, hit_start, hit_stop, hit_aux, hit_ma, hit_mb;
  assign hit_set = (idx == dsitp_pkg::IDX_OUT_SET);
  assign hit_clr = (idx == dsitp_pkg::IDX_OUT_CLR);
  assign hit_st = (idx == dsitp_pkg::IDX_IRQ_STATUS);
  assign hit_mask = (idx == dsitp_pkg::IDX_IRQ_MASK);
  assign hit_ch = (idx == dsitp_pkg::IDX_CUR_HIGH);
  assign hit_cl = (idx == dsitp_pkg::IDX_CUR_LOW);
  assign hit_ph = (idx == dsitp_pkg::IDX_PRE_HIGH);
  assign hit_pl = (idx == dsitp_pkg::IDX_PRE_LOW);
  assign hit_vec = (idx == dsitp_pkg::IDX_VECTOR);
  assign hit_in = (idx == dsitp_pkg::IDX_INPUT);
  assign hit_func = (idx == dsitp_pkg::IDX_OUT_FUNC);
  assign hit_start = (idx == dsitp_pkg::IDX_START);
  assign hit_stop = (idx == dsitp_pkg::IDX_STOP);
  assign hit_aux = (idx == dsitp_pkg::IDX_AUX);
  assign hit_ma = (idx == dsitp_pkg::IDX_MODE_A);
  assign hit_mb = (idx == dsitp_pkg::IDX_MODE_B);
  assign hit_any = hit_set | hit_clr | hit_st | hit_mask | hit_ch | hit_cl | hit_ph
                 | hit_pl | hit_vec | hit_in | hit_func | hit_start | hit_stop
                 | hit_aux | hit_ma | hit_mb;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] mask_q, vec_q, func_q, aux_q, mode_a_q, mode_b_q, pre_hi_q, pre_lo_q;
  logic [7:0] opd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= dsitp_pkg::BYTE_ZERO;
      vec_q <= dsitp_pkg::VECTOR_RST;
      func_q <= dsitp_pkg::BYTE_ZERO;
      aux_q <= dsitp_pkg::BYTE_ZERO;
      mode_a_q <= dsitp_pkg::BYTE_ZERO;
      mode_b_q <= dsitp_pkg::BYTE_ZERO;
      pre_hi_q <= dsitp_pkg::BYTE_ZERO;
      pre_lo_q <= dsitp_pkg::BYTE_ZERO;
    end else if (wr_en) begin
      if (hit_mask) mask_q <= wbyte;
      if (hit_vec) vec_q <= wbyte;
      if (hit_func) func_q <= wbyte;
      if (hit_aux) aux_q <= wbyte;
      if (hit_ma) mode_a_q <= wbyte;
      if (hit_mb) mode_b_q <= wbyte;
      if (hit_ph) pre_hi_q <= wbyte;
      if (hit_pl) pre_lo_q <= wbyte;
    end
  end

  // Output port data: set and reset commands touch only the one bits
  logic [7:0] opd_d;
  assign opd_d = (wr_en & hit_set) ? (opd_q | wbyte) :
                 (wr_en & hit_clr) ? (opd_q & ~wbyte) :
                 opd_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) opd_q <= dsitp_pkg::BYTE_ZERO;
    else opd_q <= opd_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input pins and change detection
  logic [2:0] pins_s;
  logic [2:0] pins_prev_q;
  logic [2:0] pin_change;
  logic cos_event;
  dsitp_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(input_pins),
    .sync_out(pins_s)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pins_prev_q <= '0;
    else pins_prev_q <= pins_s;
  end
  assign pin_change = pins_s ^ pins_prev_q;
  assign cos_event = |(pin_change & aux_q[dsitp_pkg::AUX_IEC_MSB:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: change, break and done flags sticky, set wins over a clear in the same cycle
  logic cos_q, brk_a_q, brk_b_q, done_q;
  logic st_clr_wr;
  logic stop_rd, start_rd;
  logic [7:0] status_w;
  assign st_clr_wr = wr_en & hit_st;
  assign stop_rd = rd_en & hit_stop;
  assign start_rd = rd_en & hit_start;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cos_q <= 1'b0;
      brk_a_q <= 1'b0;
      brk_b_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cos_q <= cos_event | (cos_q & ~(st_clr_wr & wbyte[dsitp_pkg::ST_COS]));
      brk_a_q <= chan_a_break_event
               | (brk_a_q & ~(st_clr_wr & wbyte[dsitp_pkg::ST_BRK_A]));
      brk_b_q <= chan_b_break_event
               | (brk_b_q & ~(st_clr_wr & wbyte[dsitp_pkg::ST_BRK_B]));
      done_q <= count_done_event | (done_q & ~stop_rd);
    end
  end

  // Receiver flag choice follows mode-one bit 6 of each channel
  logic rx_a_flag, rx_b_flag;
  assign rx_a_flag = mode_a_q[dsitp_pkg::MODE_RF_BIT] ? chan_a_fifo_full : chan_a_rx_ready;
  assign rx_b_flag = mode_b_q[dsitp_pkg::MODE_RF_BIT] ? chan_b_fifo_full : chan_b_rx_ready;

  assign status_w = {cos_q, brk_b_q, rx_b_flag, chan_b_tx_ready,
                     done_q, brk_a_q, rx_a_flag, chan_a_tx_ready};

  // Level output, registered so it stays glitch free at the pin
  logic irq_d;
  assign irq_d = |(status_w & mask_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= irq_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter/timer commands
  logic counter_mode;
  logic ctr_out_hold_q;
  assign counter_mode = ~aux_q[dsitp_pkg::AUX_TIMER_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_start <= 1'b0;
      counter_stop <= 1'b0;
      counter_preload <= 16'h0000;
      timer_mode <= 1'b0;
      ctr_out_hold_q <= 1'b0;
    end else begin
      counter_start <= start_rd;
      counter_stop <= stop_rd;
      counter_preload <= {pre_hi_q, pre_lo_q};
      timer_mode <= ~counter_mode;
      if (stop_rd & counter_mode) ctr_out_hold_q <= 1'b1;
      else if (start_rd) ctr_out_hold_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output port routing
  logic ctr_out_eff;
  logic src3, src2;
  logic [3:0] pin_src;
  assign ctr_out_eff = counter_output & ~ctr_out_hold_q;
  assign src3 = (func_q[3:2] == dsitp_pkg::ROUTE_DATA) ? opd_q[3] :
                (func_q[3:2] == dsitp_pkg::ROUTE_ALT1) ? ctr_out_eff :
                (func_q[3:2] == dsitp_pkg::ROUTE_ALT2) ? chan_b_tx_clock :
                chan_b_rx_clock;
  assign src2 = (func_q[1:0] == dsitp_pkg::ROUTE_DATA) ? opd_q[2] :
                (func_q[1:0] == dsitp_pkg::ROUTE_ALT1) ? chan_a_tx16_clock :
                (func_q[1:0] == dsitp_pkg::ROUTE_ALT2) ? chan_a_tx_clock :
                chan_a_rx_clock;
  assign pin_src = {src3, src2, opd_q[1:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) output_pins <= 4'hf;
    else output_pins <= ~pin_src;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, captured in the setup phase so the access phase ends at once
  logic [7:0] rd_byte;
  logic [7:0] in_byte;
  assign in_byte = {2'h0, dsitp_pkg::UNPINNED_ONES, pins_s};
  assign rd_byte = hit_st ? status_w :
                   hit_mask ? mask_q :
                   hit_ch ? counter_value[15:8] :
                   hit_cl ? counter_value[7:0] :
                   hit_vec ? vec_q :
                   hit_in ? in_byte :
                   hit_aux ? aux_q :
                   hit_ma ? mode_a_q :
                   hit_mb ? mode_b_q :
                   dsitp_pkg::BYTE_ZERO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= {24'h000000, rd_byte};
        pslverr <= ~hit_any;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  assign irq_vector = vec_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_st;
    setup_ph && !pwrite && hit_st;
  endsequence
  sequence s_set_wr;
    wr_en && hit_set;
  endsequence

  a_irq_level_gate: assert property (##1 irq == $past(|(status_w & mask_q)))
    else $error("irq does not follow enabled flags");
  a_irq_holds_level: assert property ((|(status_w & mask_q)) [*2] |=> irq)
    else $error("irq dropped while enabled flag set");
  a_status_unmasked: assert property (s_rd_st |=> prdata[7:0] == $past(status_w))
    else $error("status read altered by mask");
  a_rx_flag_pick: assert property (s_rd_st |=>
      prdata[dsitp_pkg::ST_RX_A] == $past(mode_a_q[dsitp_pkg::MODE_RF_BIT] ?
                                          chan_a_fifo_full : chan_a_rx_ready))
    else $error("rx flag wrong source");
  a_done_sets: assert property (count_done_event |=> done_q)
    else $error("ready flag not set");
  a_stop_clears: assert property (stop_rd && !count_done_event |=> !done_q)
    else $error("stop read left ready flag");
  a_start_pulse: assert property (start_rd |=> counter_start ##1 !counter_start)
    else $error("start pulse wrong");
  a_set_bits: assert property (s_set_wr |=> opd_q == ($past(opd_q) | $past(wbyte)))
    else $error("set command wrong");
  a_clr_bits: assert property (wr_en && hit_clr |=> opd_q == ($past(opd_q) & ~$past(wbyte)))
    else $error("reset command wrong");
  a_pin_invert: assert property (##1 output_pins == ~$past(pin_src))
    else $error("pins not inverted");
  a_input_ones: assert property (setup_ph && !pwrite && hit_in |=> prdata[5:3] == 3'h7)
    else $error("unpinned bits not one");
  a_break_sets: assert property (chan_b_break_event |=> brk_b_q)
    else $error("break flag not set");
  a_cos_sets: assert property (cos_event |=> cos_q)
    else $error("change flag not set");
  a_vector_write: assert property (wr_en && hit_vec |=> vec_q == $past(wbyte))
    else $error("vector write lost");
endmodule

//--- dsitp_cpu_model.sv
// CPU-side APB master model for the register bank
`timescale 1ns/1ps
module dsitp_cpu_model (
  // APB master
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer; waits on pready with no bound, the bench watchdog cuts hangs
  task automatic xfer(input logic w, input logic [29:0] idx, input logic [7:0] d,
                      output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- dsitp_regs_tb.sv
// Self-checking testbench for the interrupt, counter and port register bank
`timescale 1ns/1ps
module dsitp_regs_tb;
  typedef struct {logic w; logic [29:0] idx; logic [7:0] d; logic [7:0] e; logic ee;} dsitp_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  // Channel lines: {b_brk, b_tx, b_full, b_rx, a_brk, a_tx, a_full, a_rx}
  logic [7:0] chs = 8'h00;
  // Clocks: {b_rx, b_tx, a_rx, a_tx, a_tx16}
  logic [4:0] clks = 5'h00;
  logic [15:0] cval = 16'h0000;
  logic cout = 1'b0;
  logic cdone = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [15:0] preload;
  logic cstart, cstop, tmode, irq;
  logic [3:0] opins;
  logic [7:0] ivec, rd;
  logic err;
  int errors = 0;
  int total_checks = 0;
  dsitp_row_t rows[8] = '{
    '{1'b0, dsitp_pkg::IDX_VECTOR, 8'h00, 8'h0f, 1'b0},
    '{1'b0, dsitp_pkg::IDX_IRQ_MASK, 8'h00, 8'h00, 1'b0},
    '{1'b1, dsitp_pkg::IDX_VECTOR, 8'ha5, 8'h00, 1'b0},
    '{1'b0, dsitp_pkg::IDX_VECTOR, 8'h00, 8'ha5, 1'b0},
    '{1'b1, dsitp_pkg::IDX_PRE_HIGH, 8'h12, 8'h00, 1'b0},
    '{1'b1, dsitp_pkg::IDX_PRE_LOW, 8'h34, 8'h00, 1'b0},
    '{1'b0, dsitp_pkg::IDX_PRE_HIGH, 8'h00, 8'h00, 1'b0},
    '{1'b0, 30'h0ffff7f0, 8'h00, 8'h00, 1'b1}};

  always #5 pclk = ~pclk;

  dsitp_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  dsitp_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_a_rx_ready(chs[0]), .chan_a_fifo_full(chs[1]),
    .chan_a_tx_ready(chs[2]), .chan_a_break_event(chs[3]), .chan_b_rx_ready(chs[4]),
    .chan_b_fifo_full(chs[5]), .chan_b_tx_ready(chs[6]), .chan_b_break_event(chs[7]),
    .chan_a_tx16_clock(clks[0]), .chan_a_tx_clock(clks[1]), .chan_a_rx_clock(clks[2]),
    .chan_b_tx_clock(clks[3]), .chan_b_rx_clock(clks[4]), .counter_value(cval),
    .counter_output(cout), .count_done_event(cdone), .counter_preload(preload),
    .counter_start(cstart), .counter_stop(cstop), .timer_mode(tmode), .input_pins(pins),
    .output_pins(opins), .irq(irq), .irq_vector(ivec));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [29:0] idx, input logic [7:0] e);
    i_cpu.xfer(1'b0, idx, 8'h00, rd, err);
    chk("rdata", {8'h00, e}, {8'h00, rd});
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    i_cpu.xfer(1'b1, idx, d, rd, err);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    chk("opins", 4'hf, opins);
    chk("ivec", 8'h0f, ivec);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      i_cpu.xfer(rows[i].w, rows[i].idx, rows[i].d, rd, err);
      if (!rows[i].w)
        chk("rdata", rows[i].e, rd);
      chk("pslverr", rows[i].ee, err);
    end
    chk("preload", 16'h1234, preload);
    chk("ivec", 8'ha5, ivec);
    // Unpinned bits read high beside the live pins
    @(posedge pclk) pins <= 3'h5;
    repeat (6) @(posedge pclk);
    rchk(dsitp_pkg::IDX_INPUT, 8'h3d);
    // Enabled pin edge flags, disabled pin edge does not
    wr(dsitp_pkg::IDX_AUX, 8'h01);
    @(posedge pclk) pins <= 3'h4;
    repeat (6) @(posedge pclk);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h80);
    wr(dsitp_pkg::IDX_IRQ_STATUS, 8'h80);
    @(posedge pclk) pins <= 3'h6;
    repeat (6) @(posedge pclk);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h00);
    @(posedge pclk) chs <= 8'h41;
    repeat (3) @(posedge pclk);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h12);
    wr(dsitp_pkg::IDX_MODE_A, 8'h40);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h10);
    @(posedge pclk) chs <= 8'h43;
    repeat (3) @(posedge pclk);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h12);
    // Back-to-back break pulses on both channels
    @(posedge pclk) chs <= 8'h08;
    @(posedge pclk) chs <= 8'h80;
    @(posedge pclk) chs <= 8'h00;
    repeat (3) @(posedge pclk);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h44);
    wr(dsitp_pkg::IDX_IRQ_STATUS, 8'h44);
    wr(dsitp_pkg::IDX_OUT_SET, 8'h0b);
    repeat (2) @(posedge pclk);
    chk("opins", 4'h4, opins);
    wr(dsitp_pkg::IDX_OUT_CLR, 8'h01);
    repeat (2) @(posedge pclk);
    chk("opins", 4'h5, opins);
    for (int k = 1; k < 4; k++) begin
      wr(dsitp_pkg::IDX_OUT_FUNC, {4'h0, k[1:0], k[1:0]});
      @(posedge pclk) {clks[4:3], cout} <= 3'h1 << (k - 1);
      clks[2:0] <= 3'h1 << (k - 1);
      repeat (2) @(posedge pclk);
      chk("opins", 4'h1, opins);
      @(posedge pclk) {clks[4:3], cout} <= ~(3'h1 << (k - 1));
      clks[2:0] <= ~(3'h1 << (k - 1));
      repeat (2) @(posedge pclk);
      chk("opins", 4'hd, opins);
    end
    wr(dsitp_pkg::IDX_OUT_FUNC, 8'h04);
    @(posedge pclk) cout <= 1'b1;
    clks <= 5'h00;
    cdone <= 1'b1;
    @(posedge pclk) cdone <= 1'b0;
    repeat (3) @(posedge pclk);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h08);
    chk("irq", 1'b0, irq);
    wr(dsitp_pkg::IDX_IRQ_MASK, 8'hf7);
    repeat (3) @(posedge pclk);
    chk("irq", 1'b0, irq);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h08);
    wr(dsitp_pkg::IDX_IRQ_MASK, 8'h08);
    repeat (3) @(posedge pclk);
    chk("irq", 1'b1, irq);
    chk("opins", 4'h5, opins);
    rchk(dsitp_pkg::IDX_STOP, 8'h00);
    @(negedge pclk) chk("cstop", 1'b1, cstop);
    repeat (3) @(posedge pclk);
    chk("irq", 1'b0, irq);
    chk("opins", 4'hd, opins);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h00);
    rchk(dsitp_pkg::IDX_START, 8'h00);
    @(negedge pclk) chk("cstart", 1'b1, cstart);
    repeat (2) @(posedge pclk);
    chk("opins", 4'h5, opins);
    @(posedge pclk) cval <= 16'hbeef;
    rchk(dsitp_pkg::IDX_CUR_HIGH, 8'hbe);
    rchk(dsitp_pkg::IDX_CUR_LOW, 8'hef);
    // Timer mode: stop clears the ready flag but leaves the routed output alone
    wr(dsitp_pkg::IDX_AUX, 8'h41);
    @(posedge pclk) cdone <= 1'b1;
    @(posedge pclk) cdone <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("tmode", 1'b1, tmode);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h08);
    rchk(dsitp_pkg::IDX_STOP, 8'h00);
    repeat (2) @(posedge pclk);
    chk("opins", 4'h5, opins);
    rchk(dsitp_pkg::IDX_IRQ_STATUS, 8'h00);
    // Mid-run reset brings every output back to its reset value
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk);
    chk("opins", 4'hf, opins);
    chk("ivec", 8'h0f, ivec);
    chk("irq", 1'b0, irq);
    chk("tmode", 1'b0, tmode);
    chk("preload", 16'h0000, preload);
    @(posedge pclk) presetn <= 1'b1;
    rchk(dsitp_pkg::IDX_IRQ_MASK, 8'h00);
    rchk(dsitp_pkg::IDX_VECTOR, 8'h0f);
    print_verdict();
  end

  // Watchdog, well past the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    print_verdict();
  end
endmodule
